// File: hdl/led_pkg.sv
package led_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  typedef logic [7:0] reg_byte_t;
  localparam int unsigned NUM_REGS = 10;
  localparam reg_byte_t REG_FIRST = 8'h01;
  localparam reg_byte_t REG_LAST = 8'h0a;
  localparam reg_byte_t REG_FAULT_FLAGS = 8'h07;
  localparam reg_byte_t REG_WRITE_LOCK = 8'h09;
  localparam reg_byte_t UNLOCK_KEY = 8'hc5;

  // bank image, fields in register order 01h..0Ah
  typedef struct packed {
    reg_byte_t global_cfg;
    reg_byte_t low_channel_control;
    reg_byte_t fade_up_time_cfg;
    reg_byte_t fade_down_time_cfg;
    reg_byte_t ch1_current_level;
    reg_byte_t ch2_current_level;
    reg_byte_t fault_flags_dim_enable;
    reg_byte_t open_fault_config;
    reg_byte_t write_lock;
    reg_byte_t protection_config;
  } cfg_bank_t;
  localparam cfg_bank_t CFG_RST = '{8'h84, 8'h00, 8'h64, 8'h64, 8'h00,
                                    8'h00, 8'h00, 8'h1a, 8'h00, 8'h78};

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int unsigned GC_THERMAL = 7;
  localparam int unsigned GC_UV_SEL = 6;
  localparam int unsigned GC_LOW_SRC = 5;
  localparam int unsigned GC_FADE_UP = 4;
  localparam int unsigned GC_FADE_DN = 3;
  localparam int unsigned GC_DIM_SRC = 2;
  localparam int unsigned GC_EN_MODE = 0;
  localparam int unsigned LC_ON = 4;
  localparam int unsigned FF_DIM_EN = 7;
  localparam int unsigned PC_TSD_RPT = 6;
  localparam int unsigned PC_SHORT_RPT = 5;
  localparam int unsigned PC_SHORT_DET = 4;
  localparam int unsigned PC_OPEN_RPT = 3;

  // read-only status of 07h D6:D0, channel 1 in the upper bit
  typedef struct packed {
    logic tsd;
    logic [1:3] open;
    logic [1:3] shrt;
  } fault_flags_t;

  // configuration driven to the analog side
  typedef struct packed {
    logic thermal_rolloff_en;
    logic fault_uv_level_sel;
    logic fade_up_time_source;
    logic fade_down_time_source;
    logic dim_external;
    logic en_pin_pulse_mode;
    logic low_current_channel_on;
    logic [2:0] low_channel_current;
    reg_byte_t fade_up_time_value;
    reg_byte_t fade_down_time_value;
    reg_byte_t ch1_level;
    reg_byte_t ch2_level;
    logic dim_enable;
    logic [3:0] open_uv_threshold;
  } drive_cfg_t;

  // ----------------------------------------
  // bus protocol
  // ----------------------------------------
  localparam logic [4:0] ADDR_FIXED = 5'h17;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_PTR = 3'b011,
    ST_WDATA = 3'b010,
    ST_RDATA = 3'b110
  } link_state_t;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned SYS_CLK_MHZ = 25;
  localparam int unsigned SHORT_DLY_MS = 5;
  localparam int unsigned SHORT_DLY_CYC = SHORT_DLY_MS * 1000 * SYS_CLK_MHZ;
  typedef int unsigned dly_tab_t [16];
  localparam dly_tab_t OPEN_DLY_US = '{55, 110, 225, 450, 910, 1820, 3640,
    7280, 14520, 29000, 58000, 116000, 232000, 460000, 920000, 1840000};

  function automatic dly_tab_t us_to_cyc(dly_tab_t t);
    dly_tab_t r;
    for (int i = 0; i < 16; i++) begin
      r[i] = t[i] * SYS_CLK_MHZ;
    end
    return r;
  endfunction

  localparam dly_tab_t OPEN_DLY_CYC_DEF = us_to_cyc(OPEN_DLY_US);

endpackage

// File: hdl/sync2.sv
`timescale 1ns/100ps
module sync2 #(
  parameter int W = 1
) (
  // clock of the receiving domain
  input wire logic clk,
  // asynchronous level in, synchronised level out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_ff;

  // two flops, the first read only by the second
  always_ff @(posedge clk) begin
    meta_ff <= d;
    q <= meta_ff;
  end

endmodule

// File: hdl/persist_timer.sv
`timescale 1ns/100ps
module persist_timer #(
  parameter int W = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // condition, its enable and the persistence in cycles
  input wire logic en,
  input wire logic cond,
  input wire logic [W-1:0] limit,
  // condition has held for limit cycles
  output logic flag
);

  logic [W-1:0] cnt_ff;

  // count while the condition holds, saturate at the limit
  always_ff @(posedge clk) begin
    if (!rst_n || !(en && cond)) begin
      cnt_ff <= '0;
      flag <= 1'b0;
    end else begin
      if (cnt_ff < limit) begin
        cnt_ff <= cnt_ff + W'(1);
      end
      flag <= (cnt_ff + W'(1)) >= limit;
    end
  end

endmodule

// File: hdl/led_i2c_port.sv
`timescale 1ns/100ps
module led_i2c_port #(
  parameter led_pkg::dly_tab_t OPEN_DLY_CYC = led_pkg::OPEN_DLY_CYC_DEF,
  parameter int unsigned SHORT_DLY_CYC = led_pkg::SHORT_DLY_CYC
) (
  // system clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // bus sampling clock
  input wire logic link_clk,
  // two-wire bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // strap connection code, 2 bits
  input wire logic [1:0] ad_code,
  // analog detectors and low channel pin
  input wire logic low_channel_pin,
  input wire logic [1:3] open_det,
  input wire logic [1:3] short_det,
  input wire logic tsd_det,
  // fault pin, open drain
  output logic fault_o,
  output logic fault_oe,
  // configuration and status to the analog side
  output led_pkg::drive_cfg_t drive_cfg,
  output led_pkg::fault_flags_t fault_flags
);

  // ----------------------------------------
  // link domain: synchronisers and edges
  // ----------------------------------------
  logic link_rst_n;
  logic scl_s;
  logic sda_s;
  logic [1:0] ad_s;
  logic req_s;
  logic scl_d_ff;
  logic sda_d_ff;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  sync2 #(.W(5)) u_link_sync (
    .clk(link_clk),
    .d({rst_n, scl_i, sda_i, ad_code}),
    .q({link_rst_n, scl_s, sda_s, ad_s})
  );

  // previous sampled bus levels
  always_ff @(posedge link_clk) begin
    scl_d_ff <= scl_s;
    sda_d_ff <= sda_s;
  end

  // bus events from sampled levels
  assign scl_rise = scl_s && !scl_d_ff;
  assign scl_fall = !scl_s && scl_d_ff;
  assign start_cond = scl_s && scl_d_ff && !sda_s && sda_d_ff;
  assign stop_cond = scl_s && scl_d_ff && sda_s && !sda_d_ff;

  // ----------------------------------------
  // address strap
  // ----------------------------------------
  logic [1:0] strap_ff;
  logic strap_done_ff;
  logic addr_hit;

  // strap caught once after reset release
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      strap_ff <= 2'h0;
      strap_done_ff <= 1'b0;
    end else if (!strap_done_ff) begin
      strap_ff <= ad_s;
      strap_done_ff <= 1'b1;
    end
  end

  // ----------------------------------------
  // protocol engine
  // ----------------------------------------
  led_pkg::link_state_t st_ff;
  logic [3:0] bit_cnt_ff;
  logic ack_ph_ff;
  logic mst_nack_ff;
  led_pkg::reg_byte_t rx_ff;
  led_pkg::reg_byte_t tx_ff;
  led_pkg::reg_byte_t ptr_ff;
  led_pkg::reg_byte_t rd_data;
  logic byte_done;

  assign addr_hit = rx_ff[7:1] == {led_pkg::ADDR_FIXED, strap_ff};
  assign byte_done = scl_fall && !ack_ph_ff
                     && bit_cnt_ff == led_pkg::BYTE_BITS;

  // byte framing, ack drive, pointer and read shifter
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      st_ff <= led_pkg::ST_IDLE;
      bit_cnt_ff <= 4'h0;
      ack_ph_ff <= 1'b0;
      mst_nack_ff <= 1'b0;
      rx_ff <= 8'h00;
      tx_ff <= 8'h00;
      ptr_ff <= 8'h00;
      sda_oe <= 1'b0;
    end else if (start_cond) begin
      // plain or repeated start, pointer kept
      st_ff <= led_pkg::ST_ADDR;
      bit_cnt_ff <= 4'h0;
      ack_ph_ff <= 1'b0;
      sda_oe <= 1'b0;
    end else if (stop_cond) begin
      st_ff <= led_pkg::ST_IDLE;
      ack_ph_ff <= 1'b0;
      sda_oe <= 1'b0;
    end else if (st_ff != led_pkg::ST_IDLE) begin
      if (scl_rise) begin
        if (ack_ph_ff) begin
          mst_nack_ff <= sda_s;
        end else if (bit_cnt_ff != led_pkg::BYTE_BITS) begin
          rx_ff <= {rx_ff[6:0], sda_s};
          bit_cnt_ff <= bit_cnt_ff + 4'h1;
        end
      end else if (scl_fall && ack_ph_ff) begin
        // end of ack pulse
        ack_ph_ff <= 1'b0;
        bit_cnt_ff <= 4'h0;
        sda_oe <= 1'b0;
        if (st_ff == led_pkg::ST_RDATA) begin
          if (mst_nack_ff) begin
            st_ff <= led_pkg::ST_IDLE;
          end else begin
            tx_ff <= rd_data;
            sda_oe <= !rd_data[7];
          end
        end
      end else if (byte_done) begin
        // eighth bit done, enter ack pulse
        ack_ph_ff <= 1'b1;
        mst_nack_ff <= 1'b0;
        case (st_ff)
          led_pkg::ST_ADDR: begin
            if (addr_hit) begin
              sda_oe <= 1'b1;
              if (rx_ff[0]) begin
                st_ff <= led_pkg::ST_RDATA;
              end else begin
                st_ff <= led_pkg::ST_PTR;
              end
            end else begin
              st_ff <= led_pkg::ST_IDLE;
            end
          end
          led_pkg::ST_PTR: begin
            ptr_ff <= rx_ff;
            sda_oe <= 1'b1;
            st_ff <= led_pkg::ST_WDATA;
          end
          led_pkg::ST_WDATA: begin
            ptr_ff <= ptr_ff + 8'h01;
            sda_oe <= 1'b1;
          end
          led_pkg::ST_RDATA: begin
            ptr_ff <= ptr_ff + 8'h01;
            sda_oe <= 1'b0;
          end
          default: begin
            st_ff <= led_pkg::ST_IDLE;
          end
        endcase
      end else if (scl_fall && st_ff == led_pkg::ST_RDATA) begin
        // next read bit, msb first
        tx_ff <= {tx_ff[6:0], 1'b0};
        sda_oe <= !tx_ff[6];
      end
    end
  end

  // line is only ever pulled low
  always_ff @(posedge link_clk) begin
    sda_o <= 1'b0;
  end

  // ----------------------------------------
  // register bank
  // ----------------------------------------
  led_pkg::reg_byte_t regs_ff [led_pkg::NUM_REGS];
  led_pkg::fault_flags_t flags_lk_ff;
  logic [3:0] idx;
  logic in_range;
  logic unlocked;
  logic wr_ok;
  logic cfg_tgl_ff;
  logic [$bits(led_pkg::cfg_bank_t)-1:0] bank_flat;
  localparam logic [3:0] LOCK_IDX =
    led_pkg::REG_WRITE_LOCK[3:0] - led_pkg::REG_FIRST[3:0];

  assign idx = ptr_ff[3:0] - led_pkg::REG_FIRST[3:0];
  assign in_range = ptr_ff >= led_pkg::REG_FIRST
                    && ptr_ff <= led_pkg::REG_LAST;
  assign unlocked = regs_ff[LOCK_IDX] == led_pkg::UNLOCK_KEY;
  assign wr_ok = byte_done && st_ff == led_pkg::ST_WDATA && in_range
                 && (unlocked || ptr_ff == led_pkg::REG_WRITE_LOCK);

  // storage, lock key gates all other writes
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      for (int k = 0; k < led_pkg::NUM_REGS; k++) begin
        regs_ff[k] <= led_pkg::CFG_RST[(led_pkg::NUM_REGS-k)*8-1 -: 8];
      end
    end else if (wr_ok) begin
      if (ptr_ff == led_pkg::REG_FAULT_FLAGS) begin
        regs_ff[idx] <= {rx_ff[7], 7'h00};
      end else begin
        regs_ff[idx] <= rx_ff;
      end
    end
  end

  // read mux, flags overlay 07h, zero out of range
  always_comb begin
    rd_data = 8'h00;
    if (in_range) begin
      rd_data = regs_ff[idx];
      if (ptr_ff == led_pkg::REG_FAULT_FLAGS) begin
        rd_data[6:0] = flags_lk_ff;
      end
    end
  end

  // flat bank image for the system side
  always_comb begin
    bank_flat = '0;
    for (int k = 0; k < led_pkg::NUM_REGS; k++) begin
      bank_flat[(led_pkg::NUM_REGS-k)*8-1 -: 8] = regs_ff[k];
    end
  end

  // toggle announces a new bank image; writes are 9 bit times apart
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      cfg_tgl_ff <= 1'b0;
    end else if (wr_ok) begin
      cfg_tgl_ff <= !cfg_tgl_ff;
    end
  end

  // ----------------------------------------
  // flag handshake, link side
  // ----------------------------------------
  logic req_d_ff;
  logic ack_ff;
  logic req_ff;
  led_pkg::fault_flags_t snap_ff;

  sync2 #(.W(1)) u_req_sync (
    .clk(link_clk),
    .d(req_ff),
    .q(req_s)
  );

  // capture the held snapshot on a request toggle
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      req_d_ff <= 1'b0;
      ack_ff <= 1'b0;
      flags_lk_ff <= '0;
    end else begin
      req_d_ff <= req_s;
      ack_ff <= req_s;
      if (req_s != req_d_ff) begin
        flags_lk_ff <= snap_ff;
      end
    end
  end

  // ----------------------------------------
  // system domain
  // ----------------------------------------
  logic cfg_tgl_s;
  logic ack_s;
  logic low_pin_s;
  logic [1:3] open_s;
  logic [1:3] short_s;
  logic tsd_s;
  logic cfg_tgl_d_ff;
  led_pkg::cfg_bank_t cfg_ff;
  led_pkg::fault_flags_t flags_now;

  sync2 #(.W(10)) u_sys_sync (
    .clk(sys_clk),
    .d({cfg_tgl_ff, ack_ff, low_channel_pin, open_det, short_det,
        tsd_det}),
    .q({cfg_tgl_s, ack_s, low_pin_s, open_s, short_s, tsd_s})
  );

  // take the stable bank image after each announced write
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_tgl_d_ff <= 1'b0;
      cfg_ff <= led_pkg::CFG_RST;
    end else begin
      cfg_tgl_d_ff <= cfg_tgl_s;
      if (cfg_tgl_s != cfg_tgl_d_ff) begin
        cfg_ff <= led_pkg::cfg_bank_t'(bank_flat);
      end
    end
  end

  // persistence timers per channel
  for (genvar c = 1; c <= 3; c++) begin : g_chan
    persist_timer #(.W(32)) u_open (
      .clk(sys_clk),
      .rst_n(rst_n),
      .en(cfg_ff.protection_config[c-1]),
      .cond(open_s[c]),
      .limit(OPEN_DLY_CYC[cfg_ff.open_fault_config[7:4]]),
      .flag(flags_now.open[c])
    );
    persist_timer #(.W(32)) u_short (
      .clk(sys_clk),
      .rst_n(rst_n),
      .en(cfg_ff.protection_config[led_pkg::PC_SHORT_DET]),
      .cond(short_s[c]),
      .limit(SHORT_DLY_CYC),
      .flag(flags_now.shrt[c])
    );
  end
  assign flags_now.tsd = tsd_s;

  // send a new snapshot once the last one is acknowledged
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      req_ff <= 1'b0;
      snap_ff <= '0;
    end else if (ack_s == req_ff && flags_now != snap_ff) begin
      snap_ff <= flags_now;
      req_ff <= !req_ff;
    end
  end

  // configuration outputs
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      drive_cfg <= '0;
    end else begin
      drive_cfg.thermal_rolloff_en <=
        cfg_ff.global_cfg[led_pkg::GC_THERMAL];
      drive_cfg.fault_uv_level_sel <=
        cfg_ff.global_cfg[led_pkg::GC_UV_SEL];
      drive_cfg.fade_up_time_source <=
        cfg_ff.global_cfg[led_pkg::GC_FADE_UP];
      drive_cfg.fade_down_time_source <=
        cfg_ff.global_cfg[led_pkg::GC_FADE_DN];
      drive_cfg.dim_external <=
        cfg_ff.global_cfg[led_pkg::GC_DIM_SRC];
      drive_cfg.en_pin_pulse_mode <=
        cfg_ff.global_cfg[led_pkg::GC_EN_MODE];
      if (cfg_ff.global_cfg[led_pkg::GC_LOW_SRC]) begin
        drive_cfg.low_current_channel_on <=
          cfg_ff.low_channel_control[led_pkg::LC_ON];
      end else begin
        drive_cfg.low_current_channel_on <= low_pin_s;
      end
      drive_cfg.low_channel_current <= cfg_ff.low_channel_control[2:0];
      drive_cfg.fade_up_time_value <= cfg_ff.fade_up_time_cfg;
      drive_cfg.fade_down_time_value <= cfg_ff.fade_down_time_cfg;
      drive_cfg.ch1_level <= cfg_ff.ch1_current_level;
      drive_cfg.ch2_level <= cfg_ff.ch2_current_level;
      drive_cfg.dim_enable <=
        cfg_ff.fault_flags_dim_enable[led_pkg::FF_DIM_EN];
      drive_cfg.open_uv_threshold <= cfg_ff.open_fault_config[3:0];
    end
  end

  // fault flags and reporting pin
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fault_flags <= '0;
      fault_oe <= 1'b0;
      fault_o <= 1'b0;
    end else begin
      fault_flags <= flags_now;
      fault_o <= 1'b0;
      fault_oe <=
        (flags_now.tsd && cfg_ff.protection_config[led_pkg::PC_TSD_RPT])
        || (|flags_now.shrt
            && cfg_ff.protection_config[led_pkg::PC_SHORT_RPT])
        || (|flags_now.open
            && cfg_ff.protection_config[led_pkg::PC_OPEN_RPT]);
    end
  end

endmodule

// File: dv/led_i2c_port_sva.sv
`timescale 1ns/100ps
// checker on the port pins of the register port
module led_i2c_port_sva (
  // clocks and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic link_clk,
  // bus side
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  // detectors and fault pin
  input wire logic [1:3] open_det,
  input wire logic [1:3] short_det,
  input wire logic tsd_det,
  input wire logic fault_o,
  input wire logic fault_oe,
  // analog side
  input wire led_pkg::drive_cfg_t drive_cfg,
  input wire led_pkg::fault_flags_t fault_flags
);
  // ----------------------------------------
  // bus pin behaviour
  // ----------------------------------------
  // data pull kept through two link cycles after clock falls
  sequence oe_hold_s;
    $stable(sda_oe) ##1 $stable(sda_oe);
  endsequence
  sequence scl_fall_s;
    $fell(scl_i);
  endsequence
  property hold_after_fall_p;
    @(posedge link_clk) disable iff (!rst_n) scl_fall_s |-> oe_hold_s;
  endproperty
  chk_ack_hold_fall: assert property (hold_after_fall_p)
    else $error("data pull changed right after clock fall");
  chk_oe_stable_high: assert property (@(posedge link_clk)
    disable iff (!rst_n) scl_i && $past(scl_i) |-> $stable(sda_oe))
    else $error("data pull changed while clock high");
  chk_sda_low_only: assert property (@(posedge link_clk)
    disable iff (!rst_n) sda_o == 1'b0)
    else $error("data output not low");
  // ----------------------------------------
  // configuration and faults
  // ----------------------------------------
  chk_reset_cfg_seen: assert property (@(posedge sys_clk)
    disable iff (!rst_n) $rose(rst_n) |-> ##[1:2]
    (drive_cfg.thermal_rolloff_en && drive_cfg.dim_external))
    else $error("reset configuration not driven");
  chk_fault_pin_low: assert property (@(posedge sys_clk)
    disable iff (!rst_n) fault_o == 1'b0)
    else $error("fault output not low");
  chk_no_flag_oe: assert property (@(posedge sys_clk)
    disable iff (!rst_n) (fault_flags == 7'h00) [*3] |-> !fault_oe)
    else $error("fault pin pulled without a flag");
  chk_short_flag_clr: assert property (@(posedge sys_clk)
    disable iff (!rst_n) (short_det == 3'h0) [*5] |->
    fault_flags.shrt == 3'h0)
    else $error("short flag without short");
  chk_open_flag_clr: assert property (@(posedge sys_clk)
    disable iff (!rst_n) (open_det == 3'h0) [*5] |->
    fault_flags.open == 3'h0)
    else $error("open flag without open");
  chk_tsd_flag_clr: assert property (@(posedge sys_clk)
    disable iff (!rst_n) (!tsd_det) [*4] |-> !fault_flags.tsd)
    else $error("thermal flag without event");
endmodule

bind led_i2c_port led_i2c_port_sva led_i2c_port_sva_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk), .scl_i(scl_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .open_det(open_det),
  .short_det(short_det), .tsd_det(tsd_det), .fault_o(fault_o),
  .fault_oe(fault_oe), .drive_cfg(drive_cfg), .fault_flags(fault_flags)
);

// File: dv/i2c_ctrl_model.sv
`timescale 1ns/100ps
// bus controller: quarter-bit steps of 500 ns
module i2c_ctrl_model (
  // bus wires, data released high
  output logic scl,
  output logic sda_m,
  input wire logic sda
);
  localparam int Q = 500;
  // idle bus: both lines released
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // start or repeated start, data falls with clock high
  task automatic start();
    sda_m = 1'b1;
    #Q scl = 1'b1;
    #Q sda_m = 1'b0;
    #Q scl = 1'b0;
    #Q;
  endtask
  // stop, data rises with clock high
  task automatic stop();
    sda_m = 1'b0;
    #Q scl = 1'b1;
    #Q sda_m = 1'b1;
    #(2*Q);
  endtask
  // one clock pulse, data sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    sda_m = b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
    #Q;
  endtask
  // byte out msb first, then the ninth pulse released
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // byte in, nack on the last one ends the read
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, r);
  endtask
endmodule

// File: dv/tb_led_i2c_port.sv
`timescale 1ns/100ps
module tb_led_i2c_port;
  // ----------------------------------------
  // clocks, pins and counters
  // ----------------------------------------
  logic sys_clk, link_clk, rst_n, scl_m, sda_m, sda_o, sda_oe, sda_w;
  logic low_channel_pin, tsd_det, fault_o, fault_oe, ack;
  logic [1:0] ad_code;
  logic [1:3] open_det, short_det;
  logic [2:0] m;
  logic [7:0] wq[$], rq[$], g;
  led_pkg::drive_cfg_t drive_cfg;
  led_pkg::fault_flags_t fault_flags;
  int n_mismatch, tests_run, seed;
  int cyc = 0;
  localparam led_pkg::dly_tab_t OPEN_SIM = '{default: 20};

  led_i2c_port #(.OPEN_DLY_CYC(OPEN_SIM), .SHORT_DLY_CYC(40)) led_i2c_port_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk), .scl_i(scl_m),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .ad_code(ad_code),
    .low_channel_pin(low_channel_pin), .open_det(open_det),
    .short_det(short_det), .tsd_det(tsd_det), .fault_o(fault_o),
    .fault_oe(fault_oe), .drive_cfg(drive_cfg), .fault_flags(fault_flags));
  i2c_ctrl_model i2c_ctrl_model_i (.scl(scl_m), .sda_m(sda_m), .sda(sda_w));
  // open-drain data line with pull-up
  assign sda_w = sda_m & ~sda_oe;

  // clocks, link clock offset in phase
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #80 link_clk = ~link_clk;
  end
  // hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_mismatch++;
      complete_run();
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h want %h", $time, s, e);
    end
  endtask
  function automatic logic [7:0] rst_val(input int i);
    logic [79:0] b;
    b = led_pkg::CFG_RST;
    return b[(10-i)*8 +: 8];
  endfunction
  // pointer, nw bytes of wq written, then nr bytes read into rq
  task automatic xfer(input logic [7:0] ptr, input int nw, input int nr);
    logic [7:0] a, d;
    a = {led_pkg::ADDR_FIXED, ad_code, 1'b0};
    rq = {};
    i2c_ctrl_model_i.start();
    i2c_ctrl_model_i.wbyte(a, ack);
    chk(ack, 1);
    i2c_ctrl_model_i.wbyte(ptr, ack);
    chk(ack, 1);
    for (int i = 0; i < nw; i++) begin
      i2c_ctrl_model_i.wbyte(wq[i], ack);
      chk(ack, 1);
    end
    if (nr > 0) begin
      // writes moved the pointer: set it again before the read
      if (nw > 0) begin
        i2c_ctrl_model_i.start();
        i2c_ctrl_model_i.wbyte(a, ack);
        i2c_ctrl_model_i.wbyte(ptr, ack);
        chk(ack, 1);
      end
      i2c_ctrl_model_i.start();
      i2c_ctrl_model_i.wbyte(a | 8'h01, ack);
      chk(ack, 1);
      for (int i = 0; i < nr; i++) begin
        i2c_ctrl_model_i.rbyte(i == nr - 1, d);
        rq.push_back(d);
      end
    end
    i2c_ctrl_model_i.stop();
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 48;
    n_mismatch = 0;
    tests_run = 0;
    rst_n = 1'b0;
    open_det = 3'h0;
    short_det = 3'h0;
    tsd_det = 1'b0;
    low_channel_pin = 1'b0;
    ad_code = 2'($random(seed));
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (30) @(negedge sys_clk);
    // reset configuration and whole bank, one past each end
    chk(drive_cfg.thermal_rolloff_en, 1);
    chk(drive_cfg.dim_external, 1);
    chk(drive_cfg.fade_up_time_value, 8'h64);
    chk(drive_cfg.fade_down_time_value, 8'h64);
    chk(drive_cfg.open_uv_threshold, 4'ha);
    xfer(8'h00, 0, 12);
    chk(rq[0], 8'h00);
    chk(rq[11], 8'h00);
    for (int i = 1; i <= 10; i++) chk(rq[i], rst_val(i));
    // strap codes and a wrong fixed part: only own address answers
    for (int k = 0; k < 5; k++) begin
      g = (k < 4) ? {led_pkg::ADDR_FIXED, 2'(k), 1'b0} : {5'h16, ad_code, 1'b0};
      i2c_ctrl_model_i.start();
      i2c_ctrl_model_i.wbyte(g, ack);
      i2c_ctrl_model_i.stop();
      chk(ack, k == int'(ad_code));
    end
    // locked bank ignores writes
    wq = {8'($random(seed)) | 8'h01};
    xfer(8'h05, 1, 1);
    chk(rq[0], 8'h00);
    // unlock, burst writes and reads past the bank end
    wq = {8'hc5};
    xfer(8'h09, 1, 0);
    g = 8'($random(seed));
    wq = {g, ~g};
    xfer(8'h05, 2, 2);
    chk(rq[0], g);
    chk(rq[1], ~g);
    chk(drive_cfg.ch1_level, g);
    chk(drive_cfg.ch2_level, ~g);
    wq = {8'h7f, g};
    xfer(8'h0a, 2, 2);
    chk(rq[0], 8'h7f);
    chk(rq[1], 8'h00);
    // global configuration bits: corners then random
    wq = {8'h15};
    xfer(8'h02, 1, 0);
    for (int j = 0; j < 4; j++) begin
      g = (j == 0) ? 8'h00 : (j == 1) ? 8'hff : 8'($random(seed));
      @(negedge sys_clk);
      low_channel_pin = 1'($random(seed));
      wq = {g};
      xfer(8'h01, 1, 0);
      repeat (10) @(negedge sys_clk);
      chk(drive_cfg.thermal_rolloff_en, g[7]);
      chk(drive_cfg.fault_uv_level_sel, g[6]);
      chk(drive_cfg.low_current_channel_on, g[5] | low_channel_pin);
      chk(drive_cfg.low_channel_current, 3'h5);
      chk(drive_cfg.fade_up_time_source, g[4]);
      chk(drive_cfg.fade_down_time_source, g[3]);
      chk(drive_cfg.dim_external, g[2]);
      chk(drive_cfg.en_pin_pulse_mode, g[0]);
    end
    // open and short persistence per channel
    for (int c = 1; c <= 3; c++) begin
      m = 3'h4 >> (c - 1);
      @(negedge sys_clk);
      open_det[c] = 1'b1;
      short_det[c] = 1'b1;
      repeat (10) @(negedge sys_clk);
      chk(fault_flags, 8'h00);
      repeat (20) @(negedge sys_clk);
      chk(fault_flags.open, m);
      chk(fault_flags.shrt, 3'h0);
      repeat (25) @(negedge sys_clk);
      chk(fault_flags.shrt, m);
      chk(fault_oe, 1);
      xfer(8'h07, 0, 1);
      chk(rq[0], {2'b00, m, m});
      open_det = 3'h0;
      short_det = 3'h0;
      repeat (10) @(negedge sys_clk);
      chk(fault_flags, 8'h00);
    end
    // only the dimming enable bit of 07h takes a write
    wq = {8'hff};
    xfer(8'h07, 1, 1);
    chk(rq[0], 8'h80);
    chk(drive_cfg.dim_enable, 1);
    // thermal event pulls the fault pin
    tsd_det = 1'b1;
    repeat (8) @(negedge sys_clk);
    chk(fault_oe, 1);
    chk(fault_flags.tsd, 1);
    tsd_det = 1'b0;
    repeat (8) @(negedge sys_clk);
    complete_run();
  end
endmodule
